// ### sim/fdsw_host.sv
/*
  Host model: AHB-Lite master that reads and writes the status registers.
  Assumes one slave whose hreadyout comes back as hready.
*/
`timescale 1ns/1ps
module fdsw_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int hangs = 0;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // ****************************************************************
  // bus cycles, entered just after a rising edge
  // ****************************************************************
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) hangs++;
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    wait_rdy();
    q = hrdata;
    // stale write data is not left on the bus
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : fdsw_host

// ### sim/flow_device_status_word_tb.sv
/*
  Self-checking bench for fdsw_status with a host model on the bus.
  Assumes a 1 ms tick of 10 clocks; process inputs change on the clock.
*/
`timescale 1ns/1ps
module flow_device_status_word_tb
  import fdsw_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conn = 1'b0;
  logic rsr = 1'b0;
  logic [31:0] err_w = 32'h0000_0000;
  logic [31:0] alm_w = 32'h0000_0000;
  logic [31:0] wrn_w = 32'h0000_0000;
  fdsw_proc_t proc = '0;
  fdsw_sensor_t sens = '0;
  logic hsel, hwrite, hreadyout, hresp, zb, btn;
  logic [31:0] haddr, hwdata, hrdata, dcw, wcw, v, e, amask, wmask, rt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h0000_3BCE;
  int safe_m = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  fdsw_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  fdsw_status #(.MS_CYCLES(10)) dut (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cyclic_conn_active(conn), .reset_service_req(rsr), .error_word(err_w),
    .alarm_word(alm_w), .warning_ext_word(wrn_w), .proc_in(proc), .sensor_in(sens),
    .device_condition_word(dcw), .warning_condition_word(wcw), .zero_blocked(zb));

  // ****************************************************************
  // reference model and checking tasks
  // ****************************************************************
  function automatic logic [31:0] exp_wcw();
    return {wrn_w[31:2], 2'b00} & wmask;
  endfunction : exp_wcw

  function automatic logic [31:0] exp_dcw();
    logic [31:0] r;
    r = 32'h0000_0000;
    r[DS_EXEC] = safe_m == 0 && conn;
    r[DS_FLOW_VALID] = sens.flow_ok;
    r[DS_TEMP_VALID] = sens.temp_ok;
    r[DS_ZEROING] = proc.zero_busy;
    r[DS_ZERO_BLOCKED] = !proc.setpoint_zero || alm_w != 0 || err_w != 0
      || !(proc.valve_override inside {FDSW_VALVE_NORMAL, FDSW_VALVE_CLOSED})
      || (safe_m != 0 && proc.valve_safe_state != FDSW_VALVE_CLOSED);
    r[DS_VALVE_OVR] = proc.valve_override != FDSW_VALVE_NORMAL;
    r[DS_CTRL_OVR] = proc.ctrl_override != FDSW_CTRL_NORMAL;
    r[DS_ERROR] = err_w != 0;
    r[DS_ALARM] = (alm_w & amask) != 0;
    r[DS_WARNING] = exp_wcw() != 0;
    r[DS_BTN_DIS] = btn;
    r[DS_RAMPING] = proc.ramp_active && rt != 0;
    return r;
  endfunction : exp_dcw

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
    chk(32'(host.hangs), 32'h0000_0000, "bus stall");
    if (host.hangs != 0) stop_test();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(32'(host.hangs), 32'h0000_0000, "bus stall");
    if (host.hangs != 0) stop_test();
    chk(q, exp, m);
  endtask : rd

  // reach: wait up to n cycles for the bit; otherwise it must hold n cycles
  task automatic watch(input bit ws, input int i, input logic val, input int n,
                       input bit reach);
    logic [31:0] g;
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      g = ws ? wcw : dcw;
      if ((g[i] === val) == reach) break;
    end
    chk({31'h0, k < n}, {31'h0, reach}, "watched bit");
    if (reach && k == n) stop_test();
  endtask : watch

  task automatic zero_pulse(input logic [1:0] wz);
    wrn_w <= {26'h0, wz, 4'h0};
    proc.zero_done <= 1'b1;
    @(posedge clk);
    proc.zero_done <= 1'b0;
    @(posedge clk);
    wrn_w <= 32'h0000_0000;
  endtask : zero_pulse

  task automatic reg_check();
    rd(OFS_ALARM_MASK, 32'hFFFF_FFFF, "alarm mask");
    rd(OFS_WARNING_MASK, 32'hFFFF_FFFF, "warning mask");
    rd(OFS_FLOW_SETTLE, 32'h0000_0000, "settle");
    wr(OFS_DEVICE_COND, 32'hFFFF_FFFF);
    rd(OFS_DEVICE_COND, 32'h0000_0020, "status");
    rd(8'h3C, 32'h0000_0000, "unmapped");
    wr(OFS_FLOW_SETTLE, 32'h0000_0007);
    rd(OFS_FLOW_SETTLE, 32'h0000_0007, "settle rw");
    chk({31'h0, hresp}, 32'h0000_0000, "response");
    $display("test registers done");
  endtask : reg_check

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reg_check();
    wr(OFS_FLOW_LOW_TRIP, 32'h8000_0000);
    wr(OFS_FLOW_HIGH_TRIP, 32'h7FFF_FFFF);
    repeat (30) begin
      amask = $random(seed);
      wmask = $random(seed);
      rt = $random(seed) & 32'h0000_0001;
      v = $random(seed);
      btn = v[20];
      wr(OFS_ALARM_MASK, amask);
      wr(OFS_WARNING_MASK, wmask);
      wr(OFS_CONFIG, {31'h0, btn});
      wr(OFS_RAMP_TIME, rt);
      proc <= {v[9:1], 1'b0};
      sens <= {v[11:10], 32'($random(seed))};
      conn <= v[12];
      rsr <= v[13];
      alm_w <= v[14] ? 32'($random(seed)) : 32'h0000_0000;
      wrn_w <= $random(seed);
      err_w <= (v[16:15] == 2'b00) ? 32'($random(seed)) : 32'h0000_0000;
      repeat (3) @(posedge clk);
      safe_m = (err_w != 0) ? 1 : (rsr ? 0 : safe_m);
      e = exp_dcw();
      chk(dcw, e, "status");
      chk({31'h0, zb}, {31'h0, e[DS_ZERO_BLOCKED]}, "blocked");
      chk(wcw, exp_wcw(), "warnings");
      rd(OFS_ALARM_COND, alm_w & amask, "alarms");
      rd(OFS_ERROR_COND, err_w, "errors");
    end
    $display("test random status done");
    err_w <= 32'h0000_0000;
    alm_w <= 32'h0000_0000;
    proc <= '0;
    sens <= '0;
    @(posedge clk);
    zero_pulse(2'b00);
    wr(OFS_ZERO_REC_TIME, 32'h0000_0003);
    watch(0, DS_ZERO_REC, 1'b0, 20, 0);
    watch(0, DS_ZERO_REC, 1'b1, 40, 1);
    zero_pulse(2'b10);
    watch(0, DS_ZERO_REC, 1'b1, 10, 0);
    zero_pulse(2'b01);
    watch(0, DS_ZERO_REC, 1'b1, 10, 0);
    zero_pulse(2'b00);
    watch(0, DS_ZERO_REC, 1'b0, 5, 1);
    wr(OFS_ZERO_REC_TIME, 32'h0000_0000);
    $display("test zero time done");
    wr(OFS_ZERO_TOL_BAND, 32'h0000_000A);
    wr(OFS_ZERO_TOL_SETTLE, 32'h0000_0001);
    proc.setpoint_zero <= 1'b1;
    sens.flow <= 32'hFFFF_FFFB;
    watch(0, DS_ZERO_REC, 1'b0, 40, 0);
    sens.flow <= 32'hFFFF_FFFA;
    watch(0, DS_ZERO_REC, 1'b1, 40, 1);
    sens.flow <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    zero_pulse(2'b00);
    watch(0, DS_ZERO_REC, 1'b0, 5, 1);
    $display("test zero tolerance done");
    wmask = 32'hFFFF_FFFF;
    wr(OFS_WARNING_MASK, wmask);
    wr(OFS_FLOW_LOW_TRIP, 32'h0000_0064);
    wr(OFS_FLOW_HIGH_TRIP, 32'h0000_03E8);
    wr(OFS_FLOW_HYST, 32'h0000_0014);
    wr(OFS_FLOW_SETTLE, 32'h0000_0002);
    sens <= {2'b11, 32'h0000_0063};
    watch(1, WN_LOW_FLOW, 1'b0, 15, 0);
    sens.flow <= 32'h0000_0096;
    @(posedge clk);
    sens.flow <= 32'h0000_0063;
    watch(1, WN_LOW_FLOW, 1'b0, 15, 0);
    watch(1, WN_LOW_FLOW, 1'b1, 40, 1);
    sens.flow <= 32'h0000_006E;
    watch(1, WN_LOW_FLOW, 1'b1, 40, 0);
    chk(dcw & 32'h0000_0400, 32'h0000_0400, "warning summary");
    sens.flow <= 32'h0000_0079;
    watch(1, WN_LOW_FLOW, 1'b0, 50, 1);
    sens.flow <= 32'h0000_03E9;
    watch(1, WN_HIGH_FLOW, 1'b1, 50, 1);
    sens.flow <= 32'h0000_03D9;
    watch(1, WN_HIGH_FLOW, 1'b1, 40, 0);
    sens.flow <= 32'h0000_03D3;
    watch(1, WN_HIGH_FLOW, 1'b0, 50, 1);
    sens.flow <= 32'h0000_03E9;
    watch(1, WN_HIGH_FLOW, 1'b1, 50, 1);
    sens.flow_ok <= 1'b0;
    watch(1, WN_HIGH_FLOW, 1'b0, 5, 1);
    watch(1, WN_HIGH_FLOW, 1'b0, 40, 0);
    $display("test flow warnings done");
    sens <= '0;
    proc <= '0;
    conn <= 1'b0;
    do_reset();
    reg_check();
    chk(32'(host.hangs), 32'h0000_0000, "bus stalls");
    stop_test();
  end

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("wrong value at %0t: run did not finish", $time);
    stop_test();
  end
endmodule : flow_device_status_word_tb

// ### src/fdsw_pkg.sv
/*
  Shared constants and carrier types for the flow device status word block.
  Assumes a single 100 MHz system clock and an AHB-Lite register port.
*/
package fdsw_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1_000_000;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_DEVICE_COND = 8'h00;
  localparam logic [7:0] OFS_WARNING_COND = 8'h04;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h08;
  localparam logic [7:0] OFS_WARNING_MASK = 8'h0C;
  localparam logic [7:0] OFS_FLOW_LOW_TRIP = 8'h10;
  localparam logic [7:0] OFS_FLOW_HIGH_TRIP = 8'h14;
  localparam logic [7:0] OFS_FLOW_HYST = 8'h18;
  localparam logic [7:0] OFS_FLOW_SETTLE = 8'h1C;
  localparam logic [7:0] OFS_ZERO_REC_TIME = 8'h20;
  localparam logic [7:0] OFS_ZERO_TOL_SETTLE = 8'h24;
  localparam logic [7:0] OFS_ZERO_TOL_BAND = 8'h28;
  localparam logic [7:0] OFS_CONFIG = 8'h2C;
  localparam logic [7:0] OFS_RAMP_TIME = 8'h30;
  localparam logic [7:0] OFS_ALARM_COND = 8'h34;
  localparam logic [7:0] OFS_ERROR_COND = 8'h38;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DS_EXEC = 0;
  localparam int DS_FLOW_VALID = 1;
  localparam int DS_TEMP_VALID = 2;
  localparam int DS_ZEROING = 3;
  localparam int DS_ZERO_REC = 4;
  localparam int DS_ZERO_BLOCKED = 5;
  localparam int DS_VALVE_OVR = 6;
  localparam int DS_CTRL_OVR = 7;
  localparam int DS_ERROR = 8;
  localparam int DS_ALARM = 9;
  localparam int DS_WARNING = 10;
  localparam int DS_BTN_DIS = 11;
  localparam int DS_RAMPING = 12;
  localparam int WN_LOW_FLOW = 0;
  localparam int WN_HIGH_FLOW = 1;
  localparam int WN_ZERO_DRIFT = 4;
  localparam int WN_BAD_ZERO = 5;
  localparam int CFG_BTN_DIS = 0;

  // ****************************************************************
  // modes and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    FDSW_VALVE_NORMAL = 2'b00,
    FDSW_VALVE_OFF = 2'b01,
    FDSW_VALVE_PURGE = 2'b10,
    FDSW_VALVE_CLOSED = 2'b11
  } fdsw_valve_mode_t;

  typedef enum logic [1:0] {
    FDSW_CTRL_NORMAL = 2'b00,
    FDSW_CTRL_OFF = 2'b01,
    FDSW_CTRL_PURGE = 2'b10,
    FDSW_CTRL_FIXED = 2'b11
  } fdsw_ctrl_mode_t;

  typedef struct packed {
    logic setpoint_zero;
    fdsw_valve_mode_t valve_override;
    fdsw_valve_mode_t valve_safe_state;
    fdsw_ctrl_mode_t ctrl_override;
    logic ramp_active;
    logic zero_busy;
    logic zero_done;
  } fdsw_proc_t;

  typedef struct packed {
    logic flow_ok;
    logic temp_ok;
    logic signed [31:0] flow;
  } fdsw_sensor_t;

endpackage : fdsw_pkg

// ### src/fdsw_status.sv
/*
  Device status word and low/high flow warning generator with AHB-Lite
  register access. Assumes all process inputs come from logic on the same
  clock; the error, alarm and other warning bits arrive from other units.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module fdsw_status
  import fdsw_pkg::*;
#(
  parameter int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cyclic_conn_active,
  input wire logic reset_service_req,
  input wire logic [31:0] error_word,
  input wire logic [31:0] alarm_word,
  input wire logic [31:0] warning_ext_word,
  input wire fdsw_proc_t proc_in,
  input wire fdsw_sensor_t sensor_in,
  output logic [31:0] device_condition_word,
  output logic [31:0] warning_condition_word,
  output logic zero_blocked
);

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [31:0] alarm_mask_reg;
  logic [31:0] warning_mask_reg;
  logic signed [31:0] flow_low_trip_reg;
  logic signed [31:0] flow_high_trip_reg;
  logic [31:0] flow_hyst_reg;
  logic [31:0] flow_settle_reg;
  logic [31:0] zero_rec_time_reg;
  logic [31:0] zero_tol_settle_reg;
  logic [31:0] zero_tol_band_reg;
  logic [31:0] config_reg;
  logic [31:0] ramp_time_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] alarm_ind_reg;
  logic [31:0] error_ind_reg;

  function automatic logic fdsw_hit(input logic [31:0] addr, input logic [7:0] ofs);
    fdsw_hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == ofs);
  endfunction : fdsw_hit

  logic addr_phase;
  assign addr_phase = hsel && htrans[1] && hready;

  // address phase captured; write data lands one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_mask_reg <= RST_MASK;
      warning_mask_reg <= RST_MASK;
      flow_low_trip_reg <= RST_ZERO;
      flow_high_trip_reg <= RST_ZERO;
      flow_hyst_reg <= RST_ZERO;
      flow_settle_reg <= RST_ZERO;
      zero_rec_time_reg <= RST_ZERO;
      zero_tol_settle_reg <= RST_ZERO;
      zero_tol_band_reg <= RST_ZERO;
      config_reg <= RST_ZERO;
      ramp_time_reg <= RST_ZERO;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        OFS_ALARM_MASK: alarm_mask_reg <= hwdata;
        OFS_WARNING_MASK: warning_mask_reg <= hwdata;
        OFS_FLOW_LOW_TRIP: flow_low_trip_reg <= hwdata;
        OFS_FLOW_HIGH_TRIP: flow_high_trip_reg <= hwdata;
        OFS_FLOW_HYST: flow_hyst_reg <= hwdata;
        OFS_FLOW_SETTLE: flow_settle_reg <= hwdata;
        OFS_ZERO_REC_TIME: zero_rec_time_reg <= hwdata;
        OFS_ZERO_TOL_SETTLE: zero_tol_settle_reg <= hwdata;
        OFS_ZERO_TOL_BAND: zero_tol_band_reg <= hwdata;
        OFS_CONFIG: config_reg <= {31'h0000_0000, hwdata[CFG_BTN_DIS]};
        OFS_RAMP_TIME: ramp_time_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // read data prepared at the address phase; unmapped reads return zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_reg <= RST_ZERO;
    end else if (addr_phase && !hwrite) begin
      if (fdsw_hit(haddr, OFS_DEVICE_COND)) hrdata_reg <= device_condition_word;
      else if (fdsw_hit(haddr, OFS_WARNING_COND)) hrdata_reg <= warning_condition_word;
      else if (fdsw_hit(haddr, OFS_ALARM_MASK)) hrdata_reg <= alarm_mask_reg;
      else if (fdsw_hit(haddr, OFS_WARNING_MASK)) hrdata_reg <= warning_mask_reg;
      else if (fdsw_hit(haddr, OFS_FLOW_LOW_TRIP)) hrdata_reg <= flow_low_trip_reg;
      else if (fdsw_hit(haddr, OFS_FLOW_HIGH_TRIP)) hrdata_reg <= flow_high_trip_reg;
      else if (fdsw_hit(haddr, OFS_FLOW_HYST)) hrdata_reg <= flow_hyst_reg;
      else if (fdsw_hit(haddr, OFS_FLOW_SETTLE)) hrdata_reg <= flow_settle_reg;
      else if (fdsw_hit(haddr, OFS_ZERO_REC_TIME)) hrdata_reg <= zero_rec_time_reg;
      else if (fdsw_hit(haddr, OFS_ZERO_TOL_SETTLE)) hrdata_reg <= zero_tol_settle_reg;
      else if (fdsw_hit(haddr, OFS_ZERO_TOL_BAND)) hrdata_reg <= zero_tol_band_reg;
      else if (fdsw_hit(haddr, OFS_CONFIG)) hrdata_reg <= config_reg;
      else if (fdsw_hit(haddr, OFS_RAMP_TIME)) hrdata_reg <= ramp_time_reg;
      else if (fdsw_hit(haddr, OFS_ALARM_COND)) hrdata_reg <= alarm_ind_reg;
      else if (fdsw_hit(haddr, OFS_ERROR_COND)) hrdata_reg <= error_ind_reg;
      else hrdata_reg <= RST_ZERO;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = hrdata_reg;

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  logic [16:0] ms_div_reg;
  logic ms_tick_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_div_reg <= 17'h0_0000;
      ms_tick_reg <= 1'b0;
    end else if (ms_div_reg == 17'(MS_CYCLES - 1)) begin
      ms_div_reg <= 17'h0_0000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_div_reg <= ms_div_reg + 17'h0_0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // safe state
  // ****************************************************************
  logic safe_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) safe_reg <= 1'b0;
    else if (|error_word) safe_reg <= 1'b1;
    else if (reset_service_req) safe_reg <= 1'b0;
  end

  // ****************************************************************
  // flow warnings
  // ****************************************************************
  logic [1:0] flow_warn_reg;
  logic [31:0] flow_qual_reg [2];
  logic [1:0] warn_set_cond;
  logic [1:0] warn_clr_cond;
  logic signed [33:0] flow_x;
  logic signed [33:0] low_x;
  logic signed [33:0] high_x;
  logic signed [33:0] hyst_x;
  assign flow_x = 34'(sensor_in.flow);
  assign low_x = 34'(flow_low_trip_reg);
  assign high_x = 34'(flow_high_trip_reg);
  assign hyst_x = $signed({2'b00, flow_hyst_reg});
  assign warn_set_cond[WN_LOW_FLOW] = flow_x < low_x;
  assign warn_clr_cond[WN_LOW_FLOW] = flow_x > (low_x + hyst_x);
  assign warn_set_cond[WN_HIGH_FLOW] = flow_x > high_x;
  assign warn_clr_cond[WN_HIGH_FLOW] = flow_x < (high_x - hyst_x);

  for (genvar i = 0; i < 2; i++) begin : g_flow_warn
    logic qual;
    assign qual = flow_warn_reg[i] ? warn_clr_cond[i] : warn_set_cond[i];
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        flow_warn_reg[i] <= 1'b0;
        flow_qual_reg[i] <= RST_ZERO;
      end else if (!sensor_in.flow_ok) begin
        flow_warn_reg[i] <= 1'b0;
        flow_qual_reg[i] <= RST_ZERO;
      end else if (!qual) begin
        flow_qual_reg[i] <= RST_ZERO;
      end else if (flow_qual_reg[i] > flow_settle_reg) begin
        flow_warn_reg[i] <= !flow_warn_reg[i];
        flow_qual_reg[i] <= RST_ZERO;
      end else if (ms_tick_reg && flow_qual_reg[i] != 32'hFFFF_FFFF) begin
        flow_qual_reg[i] <= flow_qual_reg[i] + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // zero recommendation
  // ****************************************************************
  logic [31:0] since_zero_reg;
  logic [31:0] sp_zero_ms_reg;
  logic zero_rec_reg;
  logic zero_success;
  logic rec_time_cond;
  logic rec_tol_cond;
  logic [31:0] abs_flow;
  logic [32:0] abs_flow2;
  assign zero_success = proc_in.zero_done && !warning_ext_word[WN_BAD_ZERO]
    && !warning_ext_word[WN_ZERO_DRIFT];
  assign abs_flow = sensor_in.flow[31] ? (32'h0000_0000 - sensor_in.flow) : sensor_in.flow;
  assign abs_flow2 = {abs_flow, 1'b0};
  // power-on time expired; a clean zero restarts the time, so it cannot re-set
  assign rec_time_cond = (zero_rec_time_reg != RST_ZERO) && !zero_success
    && (since_zero_reg > zero_rec_time_reg);
  assign rec_tol_cond = (zero_tol_band_reg != RST_ZERO) && proc_in.setpoint_zero
    && (sp_zero_ms_reg > zero_tol_settle_reg) && (abs_flow2 > {1'b0, zero_tol_band_reg});

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) since_zero_reg <= RST_ZERO;
    else if (zero_success) since_zero_reg <= RST_ZERO;
    else if (ms_tick_reg && since_zero_reg != 32'hFFFF_FFFF)
      since_zero_reg <= since_zero_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sp_zero_ms_reg <= RST_ZERO;
    else if (!proc_in.setpoint_zero) sp_zero_ms_reg <= RST_ZERO;
    else if (ms_tick_reg && sp_zero_ms_reg != 32'hFFFF_FFFF)
      sp_zero_ms_reg <= sp_zero_ms_reg + 32'h0000_0001;
  end

  // sticky until clean zero, set wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) zero_rec_reg <= 1'b0;
    else if (rec_time_cond || rec_tol_cond) zero_rec_reg <= 1'b1;
    else if (zero_success) zero_rec_reg <= 1'b0;
  end

  // ****************************************************************
  // status words
  // ****************************************************************
  logic blocked;
  logic [31:0] warn_masked;
  logic [31:0] alarm_masked;
  logic [31:0] ds_next;
  assign blocked = !proc_in.setpoint_zero
    || (proc_in.valve_override != FDSW_VALVE_NORMAL
        && proc_in.valve_override != FDSW_VALVE_CLOSED)
    || (safe_reg && proc_in.valve_safe_state != FDSW_VALVE_CLOSED)
    || (|alarm_word) || (|error_word);
  assign alarm_masked = alarm_word & alarm_mask_reg;
  assign warn_masked = {warning_ext_word[31:2], flow_warn_reg} & warning_mask_reg;

  always_comb begin
    ds_next = RST_ZERO;
    ds_next[DS_EXEC] = !safe_reg && !(|error_word) && cyclic_conn_active;
    ds_next[DS_FLOW_VALID] = sensor_in.flow_ok;
    ds_next[DS_TEMP_VALID] = sensor_in.temp_ok;
    ds_next[DS_ZEROING] = proc_in.zero_busy;
    ds_next[DS_ZERO_REC] = zero_rec_reg;
    ds_next[DS_ZERO_BLOCKED] = blocked;
    ds_next[DS_VALVE_OVR] = proc_in.valve_override != FDSW_VALVE_NORMAL;
    ds_next[DS_CTRL_OVR] = proc_in.ctrl_override != FDSW_CTRL_NORMAL;
    ds_next[DS_ERROR] = |error_word;
    ds_next[DS_ALARM] = |alarm_masked;
    ds_next[DS_WARNING] = |warn_masked;
    ds_next[DS_BTN_DIS] = config_reg[CFG_BTN_DIS];
    ds_next[DS_RAMPING] = proc_in.ramp_active && (ramp_time_reg != RST_ZERO);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      device_condition_word <= RST_ZERO;
      warning_condition_word <= RST_ZERO;
      alarm_ind_reg <= RST_ZERO;
      error_ind_reg <= RST_ZERO;
      zero_blocked <= 1'b0;
    end else begin
      device_condition_word <= ds_next;
      warning_condition_word <= warn_masked;
      alarm_ind_reg <= alarm_masked;
      error_ind_reg <= error_word;
      zero_blocked <= blocked;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_EXEC_SAFE: assert property (|error_word |=> !device_condition_word[DS_EXEC])
    else $error("executing bit high with error present");
  AST_SAFE_HOLD: assert property (safe_reg && !reset_service_req |=> safe_reg)
    else $error("safe state left without reset");
  AST_FLOW_VALID: assert property (
    sensor_in.flow_ok |=> device_condition_word[DS_FLOW_VALID])
    else $error("flow valid bit low with healthy sensor");
  AST_BLOCK_SP: assert property (!proc_in.setpoint_zero |=> zero_blocked)
    else $error("zero not blocked with nonzero setpoint");
  AST_VALVE_OVR: assert property (
    ##1 device_condition_word[DS_VALVE_OVR]
      == ($past(proc_in.valve_override) != FDSW_VALVE_NORMAL))
    else $error("valve override bit wrong");
  AST_ERR_SUM: assert property (##1 device_condition_word[DS_ERROR] == |$past(error_word))
    else $error("error summary bit wrong");
  AST_LOW_INVALID: assert property (!sensor_in.flow_ok |=> !flow_warn_reg[WN_LOW_FLOW]
    ##1 !warning_condition_word[WN_LOW_FLOW])
    else $error("low flow warning while flow invalid");
  AST_WARN_SETTLE: assert property ($rose(flow_warn_reg[WN_HIGH_FLOW])
    |-> $past(flow_qual_reg[WN_HIGH_FLOW]) > $past(flow_settle_reg))
    else $error("high flow warning set before settling");
  AST_ZREC_CLEAR: assert property (zero_rec_reg && zero_success && !rec_tol_cond
    && !rec_time_cond |=> !zero_rec_reg ##1 !device_condition_word[DS_ZERO_REC])
    else $error("zero recommended not cleared by good zero");
  AST_BTN: assert property (
    ##1 device_condition_word[DS_BTN_DIS] == $past(config_reg[CFG_BTN_DIS]))
    else $error("button disable bit not mirrored");

endmodule : fdsw_status
